// [include/bcmp_consts.svh]
/*
 * Constants of the byte compare execution unit: register offsets,
 * field positions, reset values, opcodes and the flat page.
 * Assumes inclusion by its bare name from the design and the bench.
 */
`ifndef BCMP_CONSTS_SVH
`define BCMP_CONSTS_SVH

// APB register byte offsets
`define BCMP_OFS_CTRL      12'h000
`define BCMP_OFS_STATUS    12'h004
`define BCMP_OFS_PC        12'h008
`define BCMP_OFS_GPR       12'h00c
`define BCMP_OFS_PAGE      12'h010
`define BCMP_OFS_INDEX     12'h014
`define BCMP_OFS_FLAGS     12'h018

// Control and status bit positions
`define BCMP_CTRL_START    0
`define BCMP_CTRL_BANKED   1
`define BCMP_STAT_BUSY     0
`define BCMP_STAT_ILLEGAL  1
`define BCMP_STAT_CYC_LSB  4

// Flag register bit positions (masks, unpack, decimal, N V C Z)
`define BCMP_FLAG_N        3
`define BCMP_FLAG_V        2
`define BCMP_FLAG_C        1
`define BCMP_FLAG_Z        0

// Reset values
`define BCMP_RST_BYTE      8'h00
`define BCMP_RST_WORD      16'h0000
`define BCMP_RST_FLAGS     8'h00
`define BCMP_RST_CYC       4'h0

// Opcodes
`define BCMP_OP_PREFIX     8'hce
`define BCMP_OP_A_ABS      8'h35
`define BCMP_OP_A_PTR      8'h33
`define BCMP_OP_A_IDX0     8'h36
`define BCMP_OP_A_IDX1     8'h37
`define BCMP_OP_MEM_IMM    8'hdb
`define BCMP_OP2_DISP0     8'h30
`define BCMP_OP2_DISP1     8'h31
`define BCMP_OP2_LOFS0     8'h32
`define BCMP_OP2_LOFS1     8'h33
`define BCMP_OP2_PTR_A     8'h34
`define BCMP_OP2_B_IMM     8'hbc
`define BCMP_OP2_L_IMM     8'hbd
`define BCMP_OP2_H_IMM     8'hbe
`define BCMP_OP2_BASE_IMM  8'hbf

// Page used when the banked models are off
`define BCMP_FLAT_PAGE     8'h00

`endif

// [include/bcmp_pkg.sv]
/*
 * Types of the byte compare execution unit: state codes and the
 * packed state record of the unit.
 * Assumes bcmp_consts.svh is on the include path.
 */
package bcmp_pkg;

    typedef enum logic [2:0]
    {
        BCMP_S_IDLE = 3'b001,
        BCMP_S_READ = 3'b010,
        BCMP_S_PAD  = 3'b100
    } bcmp_state_t;

    typedef struct packed
    {
        bcmp_state_t st;
        logic [15:0] pc;
        logic [7:0]  acc;
        logic [7:0]  rb;
        logic [7:0]  rh;
        logic [7:0]  rl;
        logic [7:0]  base;
        logic [7:0]  expand_page_reg;
        logic [7:0]  x_page_reg;
        logic [7:0]  y_page_reg;
        logic [15:0] first_index_reg;
        logic [15:0] second_index_reg;
        logic [7:0]  flags;
        logic        banked;
        logic        busy;
        logic        illegal;
        logic        is_data;
        logic [1:0]  phase;
        logic [7:0]  op1;
        logic [7:0]  op2;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [3:0]  ncyc;
        logic [3:0]  last_cyc;
        logic [23:0] mem_addr;
        logic        mem_rd;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } bcmp_regs_t;

endpackage

// [rtl/bcmp_unit.sv]
/*
 * Byte compare execution unit: fetches one compare instruction from
 * memory, reads its operand, subtracts and updates N/V/C/Z only.
 * Assumes an APB master on pclk and an on-chip memory on pclk that
 * answers a held read request with a one-cycle acknowledge.
 */
// The register addresses and the APB register port are this design's own decisions.
//
// Functional notes
// - Subtract, update N V C Z, no writeback
// - 35H absolute compare takes four cycles
// - Absolute, base, pointer use expand page
// - 33H pointer pair compare, two cycles
// - 36H/37H index compare, two cycles
// - Index pages: x page, y page
// - CEH 30H/31H displacement form, four cycles
// - Displacement sign extended before adding
// - CEH 32H/33H index plus L, four cycles
// - L treated as signed offset
// - CEH BCH B immediate, three cycles
// - CEH BDH L immediate, three cycles
// - CEH BEH H immediate, three cycles
// - CEH BFH base immediate, three cycles
// - DBH memory immediate at base page, four
// - CEH 34H memory minus A, three cycles
`timescale 1ns/10ps
`include "bcmp_consts.svh"

module bcmp_unit
    import bcmp_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Data memory read port
    output logic      [23:0] mem_addr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    // Status
    output logic             busy
);

    bcmp_regs_t r;
    bcmp_regs_t n;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Flags {N,V,C,Z} of dst - src
    function automatic logic [3:0] cmp_flags(input logic [7:0] dst,
                                             input logic [7:0] src);
        logic [8:0] diff;
        diff = {1'b0, dst} - {1'b0, src};
        cmp_flags = {diff[7],
                     (dst[7] ^ src[7]) & (dst[7] ^ diff[7]),
                     diff[8],
                     diff[7:0] == 8'h00};
    endfunction

    // Page plus 16-bit logical address
    function automatic logic [23:0] phys(input logic       banked,
                                         input logic [7:0]  page,
                                         input logic [15:0] a16);
        phys = {banked ? page : `BCMP_FLAT_PAGE, a16};
    endfunction

    // Index plus signed byte offset
    function automatic logic [15:0] idx_ofs(input logic [15:0] idx,
                                            input logic [7:0]  ofs);
        idx_ofs = idx + {{8{ofs[7]}}, ofs};
    endfunction

    // Merge compare flags, keep upper four
    function automatic logic [7:0] merge(input logic [7:0] fl,
                                         input logic [3:0] nvcz);
        merge = {fl[7:4], nvcz};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state

    logic        apb_setup;
    logic        apb_wr;
    logic        unmapped;
    logic [31:0] rd_mux;
    logic        xfer;
    logic [7:0]  page_sel;
    logic [15:0] idx_sel;

    always_comb
    begin
        n         = r;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        apb_setup = psel && !penable;
        apb_wr    = psel && penable && r.pready && pwrite && !r.pslverr;
        xfer      = r.mem_rd && mem_ack;
        page_sel  = r.op2[0] ? r.y_page_reg : r.x_page_reg;
        idx_sel   = r.op2[0] ? r.second_index_reg : r.first_index_reg;
        unmapped  = 1'b0;
        rd_mux    = 32'h0000_0000;

        unique case (paddr)
            `BCMP_OFS_CTRL:
                rd_mux = {30'h0000_0000, r.banked, 1'b0};
            `BCMP_OFS_STATUS:
                rd_mux = {24'h00_0000, r.last_cyc, 2'b00,
                          r.illegal, r.busy};
            `BCMP_OFS_PC:
                rd_mux = {16'h0000, r.pc};
            `BCMP_OFS_GPR:
                rd_mux = {r.rh, r.rl, r.rb, r.acc};
            `BCMP_OFS_PAGE:
                rd_mux = {r.y_page_reg, r.x_page_reg,
                          r.expand_page_reg, r.base};
            `BCMP_OFS_INDEX:
                rd_mux = {r.second_index_reg, r.first_index_reg};
            `BCMP_OFS_FLAGS:
                rd_mux = {24'h00_0000, r.flags};
            default:
                unmapped = 1'b1;
        endcase

        // APB answers in the access phase after setup
        if (apb_setup)
        begin
            n.pready  = 1'b1;
            n.prdata  = rd_mux;
            n.pslverr = unmapped ||
                        (pwrite && r.busy && paddr != `BCMP_OFS_CTRL);
        end

        if (apb_wr)
        begin
            unique case (paddr)
                `BCMP_OFS_CTRL:
                begin
                    n.banked = pwdata[`BCMP_CTRL_BANKED];
                    if (pwdata[`BCMP_CTRL_START] && !r.busy)
                    begin
                        n.st       = BCMP_S_READ;
                        n.busy     = 1'b1;
                        n.illegal  = 1'b0;
                        n.is_data  = 1'b0;
                        n.phase    = 2'd0;
                        n.op2      = `BCMP_RST_BYTE;
                        n.ncyc     = `BCMP_RST_CYC;
                        n.mem_addr = {`BCMP_FLAT_PAGE, r.pc};
                        n.mem_rd   = 1'b1;
                    end
                end
                `BCMP_OFS_PC:
                    n.pc = pwdata[15:0];
                `BCMP_OFS_GPR:
                    {n.rh, n.rl, n.rb, n.acc} = pwdata;
                `BCMP_OFS_PAGE:
                    {n.y_page_reg, n.x_page_reg,
                     n.expand_page_reg, n.base} = pwdata;
                `BCMP_OFS_INDEX:
                    {n.second_index_reg, n.first_index_reg} = pwdata;
                `BCMP_OFS_FLAGS:
                    n.flags = pwdata[7:0];
                default:
                    n.flags = r.flags;
            endcase
        end

        unique case (r.st)
            BCMP_S_IDLE:
                n.mem_rd = n.busy;
            BCMP_S_PAD:
            begin
                // Internal cycle, then operand read at index plus L
                n.ncyc     = r.ncyc + 4'd1;
                n.st       = BCMP_S_READ;
                n.is_data  = 1'b1;
                n.mem_rd   = 1'b1;
                n.mem_addr = phys(r.banked, page_sel,
                                  idx_ofs(idx_sel, r.rl));
            end
            BCMP_S_READ:
            begin
                if (xfer && r.is_data)
                begin
                    n.ncyc     = r.ncyc + 4'd1;
                    n.last_cyc = r.ncyc + 4'd1;
                    n.mem_rd   = 1'b0;
                    n.busy     = 1'b0;
                    n.st       = BCMP_S_IDLE;
                    if (r.op1 == `BCMP_OP_MEM_IMM)
                        n.flags = merge(r.flags,
                                        cmp_flags(mem_rdata, r.b2));
                    else if (r.op1 == `BCMP_OP_PREFIX &&
                             r.op2 == `BCMP_OP2_PTR_A)
                        n.flags = merge(r.flags,
                                        cmp_flags(mem_rdata, r.acc));
                    else
                        n.flags = merge(r.flags,
                                        cmp_flags(r.acc, mem_rdata));
                end
                else if (xfer)
                begin
                    n.ncyc     = r.ncyc + 4'd1;
                    n.pc       = r.pc + 16'h0001;
                    n.phase    = r.phase + 2'd1;
                    n.mem_addr = {`BCMP_FLAT_PAGE, r.pc + 16'h0001};
                    unique case (r.phase)
                        2'd0:
                        begin
                            n.op1 = mem_rdata;
                            unique case (mem_rdata)
                                `BCMP_OP_A_ABS, `BCMP_OP_MEM_IMM,
                                `BCMP_OP_PREFIX:
                                    n.mem_rd = 1'b1;
                                `BCMP_OP_A_PTR:
                                begin
                                    n.is_data  = 1'b1;
                                    n.mem_addr = phys(r.banked,
                                                      r.expand_page_reg,
                                                      {r.rh, r.rl});
                                end
                                `BCMP_OP_A_IDX0, `BCMP_OP_A_IDX1:
                                begin
                                    n.is_data  = 1'b1;
                                    n.mem_addr = mem_rdata[0] ?
                                        phys(r.banked, r.y_page_reg,
                                             r.second_index_reg) :
                                        phys(r.banked, r.x_page_reg,
                                             r.first_index_reg);
                                end
                                default:
                                begin
                                    n.illegal = 1'b1;
                                    n.busy    = 1'b0;
                                    n.mem_rd  = 1'b0;
                                    n.st      = BCMP_S_IDLE;
                                end
                            endcase
                        end
                        2'd1:
                        begin
                            if (r.op1 == `BCMP_OP_PREFIX)
                            begin
                                n.op2 = mem_rdata;
                                unique case (mem_rdata)
                                    `BCMP_OP2_DISP0, `BCMP_OP2_DISP1,
                                    `BCMP_OP2_B_IMM, `BCMP_OP2_L_IMM,
                                    `BCMP_OP2_H_IMM,
                                    `BCMP_OP2_BASE_IMM:
                                        n.mem_rd = 1'b1;
                                    `BCMP_OP2_LOFS0, `BCMP_OP2_LOFS1:
                                    begin
                                        n.mem_rd = 1'b0;
                                        n.st     = BCMP_S_PAD;
                                    end
                                    `BCMP_OP2_PTR_A:
                                    begin
                                        n.is_data  = 1'b1;
                                        n.mem_addr = phys(r.banked,
                                                     r.expand_page_reg,
                                                     {r.rh, r.rl});
                                    end
                                    default:
                                    begin
                                        n.illegal = 1'b1;
                                        n.busy    = 1'b0;
                                        n.mem_rd  = 1'b0;
                                        n.st      = BCMP_S_IDLE;
                                    end
                                endcase
                            end
                            else
                                n.b1 = mem_rdata;
                        end
                        default:
                        begin
                            n.b2 = mem_rdata;
                            if (r.op1 == `BCMP_OP_A_ABS)
                            begin
                                n.is_data  = 1'b1;
                                n.mem_addr = phys(r.banked,
                                                  r.expand_page_reg,
                                                  {mem_rdata, r.b1});
                            end
                            else if (r.op1 == `BCMP_OP_MEM_IMM)
                            begin
                                n.is_data  = 1'b1;
                                n.mem_addr = phys(r.banked,
                                                  r.expand_page_reg,
                                                  {r.base, r.b1});
                            end
                            else if (r.op2 == `BCMP_OP2_DISP0 ||
                                     r.op2 == `BCMP_OP2_DISP1)
                            begin
                                n.is_data  = 1'b1;
                                n.mem_addr = phys(r.banked, page_sel,
                                                  idx_ofs(idx_sel,
                                                          mem_rdata));
                            end
                            else
                            begin
                                n.mem_rd   = 1'b0;
                                n.busy     = 1'b0;
                                n.st       = BCMP_S_IDLE;
                                n.last_cyc = r.ncyc + 4'd1;
                                unique case (r.op2)
                                    `BCMP_OP2_B_IMM:
                                        n.flags = merge(r.flags,
                                            cmp_flags(r.rb, mem_rdata));
                                    `BCMP_OP2_L_IMM:
                                        n.flags = merge(r.flags,
                                            cmp_flags(r.rl, mem_rdata));
                                    `BCMP_OP2_H_IMM:
                                        n.flags = merge(r.flags,
                                            cmp_flags(r.rh, mem_rdata));
                                    default:
                                        n.flags = merge(r.flags,
                                            cmp_flags(r.base, mem_rdata));
                                endcase
                            end
                        end
                    endcase
                end
            end
            default:
                n.st = BCMP_S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r          <= '0;
            r.st       <= BCMP_S_IDLE;
            r.pc       <= `BCMP_RST_WORD;
            r.flags    <= `BCMP_RST_FLAGS;
            r.last_cyc <= `BCMP_RST_CYC;
        end
        else
            r <= n;
    end

    assign prdata   = r.prdata;
    assign pready   = r.pready;
    assign pslverr  = r.pslverr;
    assign mem_addr = r.mem_addr;
    assign mem_rd   = r.mem_rd;
    assign busy     = r.busy;

endmodule

// [tb/bcmp_chk_monitor.sv]
/*
 * Port checker of the byte compare unit, bound to bcmp_unit below.
 * Assumes the unit's APB and memory read timing on pclk.
 */
`timescale 1ns/10ps
`include "bcmp_consts.svh"

module bcmp_chk_monitor
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Memory and status
    input wire logic [23:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_ack,
    input wire logic        busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       setup;
    logic       start_hit;
    logic       ack_hit;
    logic [2:0] acks_reg;

    assign setup     = psel && !penable;
    assign start_hit = psel && penable && pwrite && pwdata[0]
                       && paddr == `BCMP_OFS_CTRL;
    assign ack_hit   = mem_rd && mem_ack;

    // Acks taken by the running instruction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acks_reg <= 3'h0;
        else if (!busy)
            acks_reg <= 3'h0;
        else if (ack_hit)
            acks_reg <= acks_reg + 3'h1;
    end

////////////////////////////////////////////////////////////////////////
    AST_PREADY_PULSE: assert property (
        setup |=> pready ##1 !pready)
        else $error("pready not one pulse after setup");
    AST_UNMAPPED: assert property (
        setup && paddr > `BCMP_OFS_FLAGS |=> pslverr)
        else $error("unmapped access not refused");
    AST_BUSY_WRITE: assert property (
        setup && pwrite && busy && paddr != `BCMP_OFS_CTRL ##1 busy
        |-> pslverr)
        else $error("write while busy not refused");
    AST_START_ONLY: assert property (
        $rose(busy) |-> $past(start_hit))
        else $error("busy rose without a start write");
    AST_FETCH_PAGE: assert property (
        $rose(busy) |-> mem_rd && mem_addr[23:16] == `BCMP_FLAT_PAGE)
        else $error("first fetch not at code page");
    AST_READ_HOLD: assert property (
        mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
        else $error("read request dropped before ack");
    AST_NO_GAP: assert property (
        busy |-> mem_rd || $past(ack_hit))
        else $error("more than one idle cycle in an instruction");
    AST_READ_BUSY: assert property (
        mem_rd |-> busy)
        else $error("memory read while idle");
    AST_ACK_LIMIT: assert property (
        busy |-> acks_reg <= 3'h3)
        else $error("instruction took more than four bus cycles");

    cover property ($fell(busy));
    cover property (mem_rd && !mem_ack ##1 ack_hit);
    cover property (pready && pslverr);
endmodule

bind bcmp_unit bcmp_chk_monitor mon_u
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_addr, .mem_rd, .mem_rdata,
    .mem_ack, .busy
);

// [tb/bcmp_mem_model.sv]
/*
 * Data memory model on the unit's read port.
 * Assumes the bench loads mem and sets the stall while idle.
 */
`timescale 1ns/10ps

module bcmp_mem_model
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Read port
    input wire logic [23:0] mem_addr,
    input wire logic        mem_rd,
    output logic     [7:0]  mem_rdata,
    output logic            mem_ack,
    // Stall cycles before each ack
    input wire logic [1:0]  wait_cyc
);
    logic [7:0] mem [logic [23:0]];
    logic [1:0] cnt_reg;
    logic [7:0] last_reg;

    assign mem_ack = mem_rd && cnt_reg == wait_cyc;

    // Data only while acked, else a toggling pattern
    always_comb
    begin
        mem_rdata = ~last_reg;
        if (mem_ack && mem.exists(mem_addr))
            mem_rdata = mem[mem_addr];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg  <= 2'h0;
            last_reg <= 8'h00;
        end
        else
        begin
            last_reg <= mem_rdata;
            cnt_reg  <= (!mem_rd || mem_ack) ? 2'h0 : cnt_reg + 2'h1;
        end
    end
endmodule

// [tb/tb_top.sv]
/*
 * Self-checking bench of the byte compare unit.
 * Assumes the memory model and the bound port checker.
 */
`timescale 1ns/10ps
`include "bcmp_consts.svh"

module tb_top;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic [1:0]  wait_cyc = 2'h0;
    logic        banked   = 1'b1;
    logic [31:0] prdata;
    logic [23:0] mem_addr;
    logic [7:0]  mem_rdata;
    logic        pready, pslverr, mem_rd, mem_ack, busy;
    int          failures = 0;
    int          checks   = 0;

    bcmp_unit dut_u
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_addr, .mem_rd, .mem_rdata,
        .mem_ack, .busy
    );
    bcmp_mem_model mem_u
    (
        .pclk, .presetn, .mem_addr, .mem_rd, .mem_rdata, .mem_ack,
        .wait_cyc
    );

    always #25 pclk = ~pclk;

////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, got);
        checks++;
        if (got !== ex)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge pclk);
        if (k == 20)
        begin
            failures++;
            test_done;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic idle;
        int k;
        @(posedge pclk);
        for (k = 0; k < 100 && busy !== 1'b0; k++)
            @(posedge pclk);
        if (k == 100)
        begin
            failures++;
            test_done;
        end
    endtask

    function automatic logic [3:0] nvcz(input logic [7:0] d, s);
        logic [8:0] r;
        r = {1'b0, d} - {1'b0, s};
        return {r[7], (d[7] ^ s[7]) & (d[7] ^ r[7]), r[8], r[7:0] == 0};
    endfunction

    // Run code at 0100, operand byte at da, dst d minus src s
    task automatic ex(input logic [31:0] c, input int n,
                      input logic [23:0] da, input logic [7:0] d, s,
                      input logic [3:0] cy, input logic md);
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
            mem_u.mem[24'h100 + i] = c[31 - 8 * i -: 8];
        mem_u.mem[da] = md ? d : s;
        wr(`BCMP_OFS_PC, 32'h100);
        wr(`BCMP_OFS_CTRL, {30'h0, banked, 1'b1});
        idle;
        rd(`BCMP_OFS_STATUS, r);
        chk("cycles", {28'h0, cy}, {28'h0, r[7:4]});
        rd(`BCMP_OFS_FLAGS, r);
        chk("flags", {24'h0, 4'ha, nvcz(d, s)}, r);
        rd(`BCMP_OFS_PC, r);
        chk("pc", 32'h100 + n, r);
    endtask

    task automatic init_case;
        logic [31:0] r;
        logic        e;
        rd(`BCMP_OFS_FLAGS, r);
        chk("flags_rst", 32'h0, r);
        apb(1'b0, 12'h01c, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        wr(`BCMP_OFS_GPR, 32'h30ff743c);
        wr(`BCMP_OFS_PAGE, 32'h33221144);
        wr(`BCMP_OFS_INDEX, 32'h20001000);
        wr(`BCMP_OFS_FLAGS, 32'ha0);
    endtask

    task automatic mem_case;
        logic [31:0] r;
        wait_cyc <= 2'h2;
        ex(32'h35341200, 3, 24'h111234, 8'h3c, 8'h59, 4'h4, 0);
        banked = 1'b0;
        ex(32'h35341200, 3, 24'h001234, 8'h3c, 8'h2a, 4'h4, 0);
        banked = 1'b1;
        wait_cyc <= 2'h0;
        ex(32'h33000000, 1, 24'h1130ff, 8'h3c, 8'h3c, 4'h2, 0);
        ex(32'hce340000, 2, 24'h1130ff, 8'h59, 8'h3c, 4'h3, 1);
        ex(32'h36000000, 1, 24'h221000, 8'h3c, 8'hc3, 4'h2, 0);
        ex(32'h37000000, 1, 24'h332000, 8'h3c, 8'h2a, 4'h2, 0);
        rd(`BCMP_OFS_GPR, r);
        chk("gpr", 32'h30ff743c, r);
    endtask

    task automatic ofs_case;
        wait_cyc <= 2'h1;
        ex(32'hce308000, 3, 24'h220f80, 8'h3c, 8'h59, 4'h4, 0);
        ex(32'hce317f00, 3, 24'h33207f, 8'h3c, 8'h1d, 4'h4, 0);
        ex(32'hce320000, 2, 24'h220fff, 8'h3c, 8'h62, 4'h4, 0);
        ex(32'hce330000, 2, 24'h331fff, 8'h3c, 8'hc3, 4'h4, 0);
        wait_cyc <= 2'h0;
    endtask

    task automatic imm_case;
        logic [7:0]  v [4] = '{8'h74, 8'hff, 8'h30, 8'h44};
        logic [31:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = {8'hce, 8'hbc + 8'(i), 16'h2a00};
            ex(c, 3, 24'hffffff, v[i], 8'h2a, 4'h3, 0);
        end
        ex(32'hdb566200, 3, 24'h114456, 8'hc3, 8'h62, 4'h4, 1);
    endtask

    task automatic busy_case;
        logic [31:0] r;
        logic        e;
        wait_cyc <= 2'h3;
        wr(`BCMP_OFS_PC, 32'h100);
        wr(`BCMP_OFS_CTRL, 32'h3);
        apb(1'b1, `BCMP_OFS_PC, 32'h500, r, e);
        chk("busy_wr_err", 32'h1, {31'h0, e});
        idle;
        rd(`BCMP_OFS_PC, r);
        chk("pc_kept", 32'h103, r);
        mem_u.mem[24'h100] = 8'h00;
        wr(`BCMP_OFS_PC, 32'h100);
        wr(`BCMP_OFS_CTRL, 32'h3);
        idle;
        rd(`BCMP_OFS_STATUS, r);
        chk("illegal", 32'h2, {30'h0, r[1:0]});
        rd(`BCMP_OFS_PC, r);
        chk("pc_illegal", 32'h101, r);
        wait_cyc <= 2'h0;
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        init_case;
        mem_case;
        ofs_case;
        imm_case;
        busy_case;
        test_done;
    end
endmodule
